// File: inc/scan_chain_defs.svh
// Constants for the memory boundary scan chain
`ifndef SCAN_CHAIN_DEFS_SVH
`define SCAN_CHAIN_DEFS_SVH
`define CHAIN_LEN 67
`define POS_RESERVED_A 56
`define POS_RESERVED_B 57
`define SYNC_STAGES 2
`endif

// File: inc/scan_chain_pkg.sv
// Types shared by the scan chain modules
package scan_chain_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SCAN
    } scan_mode_t;
    typedef enum logic [1:0] {
        TERM_NORMAL,
        TERM_SCAN_CA_ONLY
    } term_mode_t;
endpackage : scan_chain_pkg

// File: inc/scan_strobe_if.sv
// Interface carrying synchronised scan inputs and strobe event
`timescale 1ns/100ps
interface scan_strobe_if;
    logic strobe_rise;
    logic mode_sel;
    logic shift_sel;
    logic oe_n;
    modport src (output strobe_rise, output mode_sel, output shift_sel, output oe_n);
    modport dst (input strobe_rise, input mode_sel, input shift_sel, input oe_n);
endinterface : scan_strobe_if

// File: rtl/scan_sync.sv
// Two-flop synchronisers and strobe edge detector
`timescale 1ns/100ps
`include "scan_chain_defs.svh"
module scan_sync (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic scan_mode_select,
    input wire logic capture_shift_select,
    input wire logic scan_strobe,
    input wire logic scan_out_enable_n,
    scan_strobe_if.src sif
);
    // ==========================================
    // Synchronisers
    // ==========================================
    logic [3:0] s1_reg;
    logic [3:0] s1_next;
    logic [3:0] s2_reg;
    logic [3:0] s2_next;
    logic strb_d_reg;
    logic strb_d_next;
    always_comb begin
        s1_next = {scan_out_enable_n, scan_strobe, capture_shift_select, scan_mode_select};
        s2_next = s1_reg;
        strb_d_next = s2_reg[2];
    end
    // Enable and strobe reset to their idle high levels, so no false edge follows reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 4'hc;
            s2_reg <= 4'hc;
            strb_d_reg <= 1'h1;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            strb_d_reg <= strb_d_next;
        end
    end
    // Single pulses and bursts both give one event per rising edge
    assign sif.strobe_rise = s2_reg[2] & ~strb_d_reg;
    assign sif.mode_sel = s2_reg[0];
    assign sif.shift_sel = s2_reg[1];
    assign sif.oe_n = s2_reg[3];
endmodule : scan_sync

// File: rtl/scan_chain_reg.sv
// Capture and shift register of the scan chain
`timescale 1ns/100ps
`include "scan_chain_defs.svh"
module scan_chain_reg #(
    parameter int LEN = `CHAIN_LEN
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic load,
    input wire logic shift,
    input wire logic [LEN-1:0] pads,
    output logic head
);
    logic [LEN-1:0] chain_reg;
    logic [LEN-1:0] chain_next;
    always_comb begin
        chain_next = chain_reg;
        if (load) begin
            chain_next = pads;
        end else if (shift) begin
            // Zero enters at the tail, so overrun reads zeros
            chain_next = {1'h0, chain_reg[LEN-1:1]};
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= chain_next;
        end
    end
    assign head = chain_reg[0];
endmodule : scan_chain_reg

// File: rtl/mem_boundary_scan.sv
// Boundary scan test port of the memory device
`timescale 1ns/100ps
`include "scan_chain_defs.svh"
module mem_boundary_scan #(
    parameter int LEN = `CHAIN_LEN
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic scan_mode_select,
    input wire logic init_hold_input,
    input wire logic mirror_select,
    input wire logic chip_select_n,
    input wire logic [LEN-1:0] pad_in,
    input wire logic norm_strobe_out,
    input wire logic norm_strobe_oe,
    input wire logic norm_init_hold,
    output logic lane0_write_strobe_out,
    output logic lane0_write_strobe_oe,
    output logic core_init_hold,
    output logic core_mirror_en,
    output logic core_chip_select_n,
    output logic core_cmd_block,
    output logic term_ca_en,
    output logic term_dq_en,
    output logic scan_active
);
    // ==========================================
    // Input synchronisation
    // ==========================================
    scan_strobe_if sif ();
    scan_sync u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .scan_mode_select(scan_mode_select),
        .capture_shift_select(init_hold_input),
        .scan_strobe(chip_select_n),
        .scan_out_enable_n(mirror_select),
        .sif(sif)
    );
    // The normal path also sees synchronised pins; the core is assumed slower than the pads here
    logic [2:0] n1_reg;
    logic [2:0] n1_next;
    logic [2:0] n2_reg;
    logic [2:0] n2_next;
    always_comb begin
        n1_next = {chip_select_n, mirror_select, norm_init_hold};
        n2_next = n1_reg;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            n1_reg <= 3'h4;
            n2_reg <= 3'h4;
        end else begin
            n1_reg <= n1_next;
            n2_reg <= n2_next;
        end
    end
    // ==========================================
    // Pad synchronisation
    // ==========================================
    // Costs two cycles of capture setup; pads settle before the strobe edge is seen
    logic [LEN-1:0] pad1_reg;
    logic [LEN-1:0] pad1_next;
    logic [LEN-1:0] pad2_reg;
    logic [LEN-1:0] pad2_next;
    always_comb begin
        pad1_next = pad_in;
        pad2_next = pad1_reg;
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pad1_reg <= '0;
            pad2_reg <= '0;
        end else begin
            pad1_reg <= pad1_next;
            pad2_reg <= pad2_next;
        end
    end
    // ==========================================
    // Pad vector with reserved positions forced low
    // ==========================================
    function automatic logic [LEN-1:0] mask_reserved(input logic [LEN-1:0] p);
        logic [LEN-1:0] r;
        r = p;
        r[`POS_RESERVED_A-1] = 1'h0;
        r[`POS_RESERVED_B-1] = 1'h0;
        return r;
    endfunction : mask_reserved
    // pad_in[0] is exit position 1 (read data pin 0); pad_in[LEN-1] is lane-0 mask
    logic [LEN-1:0] pads_masked;
    assign pads_masked = mask_reserved(pad2_reg);
    // ==========================================
    // Chain
    // ==========================================
    logic load;
    logic shift;
    logic head;
    assign load = sif.mode_sel & sif.strobe_rise & ~sif.shift_sel;
    assign shift = sif.mode_sel & sif.strobe_rise & sif.shift_sel;
    scan_chain_reg #(.LEN(LEN)) u_chain (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(load),
        .shift(shift),
        .pads(pads_masked),
        .head(head)
    );
    // ==========================================
    // Shifts since the last capture
    // ==========================================
    localparam int CNT_W = $clog2(LEN + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(LEN);
    logic [CNT_W-1:0] shift_cnt_reg;
    logic [CNT_W-1:0] shift_cnt_next;
    always_comb begin
        shift_cnt_next = shift_cnt_reg;
        if (load) begin
            shift_cnt_next = '0;
        end else if (shift && (shift_cnt_reg != CNT_FULL)) begin
            // Saturates, so a long overrun never wraps back to a live count
            shift_cnt_next = shift_cnt_reg + CNT_W'(1);
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_cnt_reg <= CNT_FULL;
        end else begin
            shift_cnt_reg <= shift_cnt_next;
        end
    end
    // ==========================================
    // Mode and output state
    // ==========================================
    scan_chain_pkg::scan_mode_t mode_reg;
    scan_chain_pkg::scan_mode_t mode_next;
    logic oe_n_reg;
    logic oe_n_next;
    // Registered copy, so the status output comes straight from a flop
    logic active_reg;
    logic active_next;
    always_comb begin
        mode_next = sif.mode_sel ? scan_chain_pkg::MODE_SCAN : scan_chain_pkg::MODE_NORMAL;
        active_next = (mode_next == scan_chain_pkg::MODE_SCAN);
        oe_n_next = oe_n_reg;
        // Enable is registered on a strobe edge in scan mode and forced off (high) outside scan
        if (sif.mode_sel && sif.strobe_rise) begin
            oe_n_next = sif.oe_n;
        end else if (!sif.mode_sel) begin
            oe_n_next = 1'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= scan_chain_pkg::MODE_NORMAL;
            oe_n_reg <= 1'h1;
            active_reg <= 1'h0;
        end else begin
            mode_reg <= mode_next;
            oe_n_reg <= oe_n_next;
            active_reg <= active_next;
        end
    end
    logic in_scan;
    assign in_scan = (mode_reg == scan_chain_pkg::MODE_SCAN);
    // ==========================================
    // Registered outputs
    // ==========================================
    logic ws_out_reg;
    logic ws_out_next;
    logic ws_oe_reg;
    logic ws_oe_next;
    logic hold_reg;
    logic hold_next;
    logic mirror_reg;
    logic mirror_next;
    logic cs_reg;
    logic cs_next;
    logic block_reg;
    logic block_next;
    logic tca_reg;
    logic tca_next;
    logic tdq_reg;
    logic tdq_next;
    always_comb begin
        if (in_scan) begin
            ws_out_next = head;
            ws_oe_next = ~oe_n_reg;
            hold_next = 1'h0;
            mirror_next = 1'h0;
            cs_next = 1'h1;
            block_next = 1'h1;
            tca_next = 1'h1;
            tdq_next = 1'h0;
        end else begin
            ws_out_next = norm_strobe_out;
            ws_oe_next = norm_strobe_oe;
            hold_next = n2_reg[0];
            mirror_next = n2_reg[1];
            cs_next = n2_reg[2];
            block_next = 1'h0;
            tca_next = 1'h1;
            tdq_next = 1'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ws_out_reg <= 1'h0;
            ws_oe_reg <= 1'h0;
            hold_reg <= 1'h1;
            mirror_reg <= 1'h0;
            cs_reg <= 1'h1;
            block_reg <= 1'h0;
            tca_reg <= 1'h1;
            tdq_reg <= 1'h1;
        end else begin
            ws_out_reg <= ws_out_next;
            ws_oe_reg <= ws_oe_next;
            hold_reg <= hold_next;
            mirror_reg <= mirror_next;
            cs_reg <= cs_next;
            block_reg <= block_next;
            tca_reg <= tca_next;
            tdq_reg <= tdq_next;
        end
    end
    assign lane0_write_strobe_out = ws_out_reg;
    assign lane0_write_strobe_oe = ws_oe_reg;
    assign core_init_hold = hold_reg;
    assign core_mirror_en = mirror_reg;
    assign core_chip_select_n = cs_reg;
    assign core_cmd_block = block_reg;
    assign term_ca_en = tca_reg;
    assign term_dq_en = tdq_reg;
    assign scan_active = active_reg;
    // ==========================================
    // Checks
    // ==========================================
    AST_MODE_ENTRY: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sif.mode_sel |=> in_scan) else $error("scan mode not entered");
    AST_MODE_EXIT: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !sif.mode_sel |=> !in_scan) else $error("scan mode not left");
    AST_MIRROR_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        in_scan |=> !core_mirror_en) else $error("mirror active in scan");
    AST_CMD_BLOCK: assert property (@(posedge clk_sys) disable iff (!arst_n)
        in_scan |=> core_cmd_block && core_chip_select_n) else $error("commands not blocked");
    AST_TERM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        in_scan |=> term_ca_en && !term_dq_en) else $error("scan termination wrong");
    AST_NORMAL_PASS: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !in_scan |=> lane0_write_strobe_out == $past(norm_strobe_out)) else $error("strobe not passed");
    AST_OE_FOLLOW: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (in_scan && $past(in_scan)) |=> lane0_write_strobe_oe == !$past(oe_n_reg)) else $error("oe mismatch");
    AST_CAPTURE_HEAD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (load && sif.mode_sel) ##1 (in_scan && !load && !shift)[*2] |-> lane0_write_strobe_out == $past(pads_masked[0], 2))
        else $error("position 1 not first");
    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !pads_masked[`POS_RESERVED_A-1] && !pads_masked[`POS_RESERVED_B-1]) else $error("reserved nonzero");
    AST_NO_EDGE_NO_MOVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !sif.strobe_rise |-> !load && !shift) else $error("chain moved without edge");
    // A full unload leaves only the grounded tail input in the chain
    AST_OVERRUN_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (shift_cnt_reg == CNT_FULL) |-> !head) else $error("chain not empty after full unload");
    AST_OUT_ZERO_AFTER_FULL: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (in_scan && (shift_cnt_reg == CNT_FULL)) |=> !lane0_write_strobe_out) else $error("overrun output not zero");
    AST_STILL_CHAIN: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!load && !shift) |=> $stable(head)) else $error("chain head moved without strobe");
    AST_NORMAL_OE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !in_scan |=> lane0_write_strobe_oe == $past(norm_strobe_oe)) else $error("strobe enable not passed");
    AST_OE_OFF_OUTSIDE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !sif.mode_sel |=> oe_n_reg) else $error("scan enable kept outside scan");
    AST_IDLE_NO_MOVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !sif.mode_sel |-> !load && !shift) else $error("chain moved outside scan");
    AST_NORMAL_TERM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !in_scan |=> term_ca_en && term_dq_en && !core_cmd_block) else $error("normal path not restored");
    COV_CAPTURE: cover property (@(posedge clk_sys) disable iff (!arst_n) load);
    COV_SHIFT: cover property (@(posedge clk_sys) disable iff (!arst_n) shift ##[1:40] shift);
    COV_OE_ON: cover property (@(posedge clk_sys) disable iff (!arst_n) in_scan && lane0_write_strobe_oe);
    COV_OVERRUN: cover property (@(posedge clk_sys) disable iff (!arst_n)
        shift && (shift_cnt_reg == CNT_FULL));
    COV_OE_OFF: cover property (@(posedge clk_sys) disable iff (!arst_n)
        in_scan && $fell(lane0_write_strobe_oe));
endmodule : mem_boundary_scan

// File: verification/scan_tester.sv
// Behavioural tester that drives the scan pins of the memory device
`timescale 1ns/100ps
module scan_tester (
    input wire logic clk_sys,
    output logic scan_mode_select,
    output logic init_hold_input,
    output logic mirror_select,
    output logic chip_select_n
);
    // ==========================================================
    // Pin state and timing helpers
    initial begin
        scan_mode_select = 1'h0;
        init_hold_input = 1'h0;
        mirror_select = 1'h0;
        chip_select_n = 1'h1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic set_pins(input logic mf, input logic cs_n);
        mirror_select = mf;
        chip_select_n = cs_n;
    endtask : set_pins
    // ==========================================================
    // Scan frames
    // Bench reset stands in for the power-up and termination setup
    task automatic enter();
        scan_mode_select = 1'h1;
        cyc(1);
        // Strobe parks low; scan forces core_chip_select_n high, so no memory command is presented in scan
        chip_select_n = 1'h0;
        cyc(3);
    endtask : enter
    // One strobe period of 8 system cycles; selects held across the edge
    task automatic strobe(input logic shift, input logic oe_n);
        init_hold_input = shift;
        mirror_select = oe_n;
        cyc(2);
        chip_select_n = 1'h1;
        cyc(4);
        chip_select_n = 1'h0;
        cyc(2);
    endtask : strobe
    // Strobe stays low on exit so no late edge is seen
    task automatic leave();
        scan_mode_select = 1'h0;
        cyc(2);
    endtask : leave
endmodule : scan_tester

// File: verification/mem_boundary_scan_tb.sv
// Self-checking bench for the memory boundary scan port
`timescale 1ns/100ps
`include "scan_chain_defs.svh"
module mem_boundary_scan_tb;
    // Bits 55 and 56 set so forced-zero positions are visible
    localparam logic [`CHAIN_LEN-1:0] PADS = 67'h5_ffa5_3c96_0f1e_d2b4;
    logic clk_sys, arst_n, norm_strobe_out, norm_strobe_oe, norm_init_hold;
    logic [`CHAIN_LEN-1:0] pad_in;
    logic scan_mode_select, init_hold_input, mirror_select, chip_select_n;
    logic lane0_write_strobe_out, lane0_write_strobe_oe, core_init_hold, core_mirror_en;
    logic core_chip_select_n, core_cmd_block, term_ca_en, term_dq_en, scan_active;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    mem_boundary_scan dut (.clk_sys(clk_sys), .arst_n(arst_n), .scan_mode_select(scan_mode_select),
        .init_hold_input(init_hold_input), .mirror_select(mirror_select), .chip_select_n(chip_select_n),
        .pad_in(pad_in), .norm_strobe_out(norm_strobe_out), .norm_strobe_oe(norm_strobe_oe),
        .norm_init_hold(norm_init_hold), .lane0_write_strobe_out(lane0_write_strobe_out),
        .lane0_write_strobe_oe(lane0_write_strobe_oe), .core_init_hold(core_init_hold),
        .core_mirror_en(core_mirror_en), .core_chip_select_n(core_chip_select_n),
        .core_cmd_block(core_cmd_block), .term_ca_en(term_ca_en), .term_dq_en(term_dq_en),
        .scan_active(scan_active));
    scan_tester tester (.clk_sys(clk_sys), .scan_mode_select(scan_mode_select),
        .init_hold_input(init_hold_input), .mirror_select(mirror_select), .chip_select_n(chip_select_n));

    // ==========================================================
    // Clock, watchdog and reporting
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Whole run is about 600 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %b", $time, what, got);
        end
    endtask : chk
    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Scenarios
    // Pin values all differ from reset, so pass-through is proven
    task automatic t_normal();
        norm_strobe_out = 1'h1;
        norm_strobe_oe = 1'h1;
        norm_init_hold = 1'h0;
        tester.set_pins(1'h1, 1'h0);
        tester.cyc(6);
        chk(scan_active, 1'h0, "active in normal");
        chk(lane0_write_strobe_out, 1'h1, "strobe out normal");
        chk(lane0_write_strobe_oe, 1'h1, "strobe oe normal");
        chk(core_init_hold, 1'h0, "init hold normal");
        chk(core_mirror_en, 1'h1, "mirror normal");
        chk(core_chip_select_n, 1'h0, "chip select normal");
        chk(core_cmd_block, 1'h0, "cmd block normal");
        chk(term_dq_en, 1'h1, "dq term normal");
    endtask : t_normal
    task automatic t_enter();
        norm_init_hold = 1'h1;
        tester.enter();
        tester.cyc(1);
        chk(scan_active, 1'h1, "active in scan");
        chk(core_mirror_en, 1'h0, "mirror in scan");
        chk(core_chip_select_n, 1'h1, "chip select in scan");
        chk(core_init_hold, 1'h0, "init hold in scan");
        chk(core_cmd_block, 1'h1, "cmd block in scan");
        chk(term_ca_en, 1'h1, "ca term in scan");
        chk(term_dq_en, 1'h0, "dq term in scan");
    endtask : t_enter
    // Capture, full unload, two overrun shifts, disable, recapture
    task automatic t_chain();
        logic exp;
        pad_in = PADS;
        tester.strobe(1'h0, 1'h0);
        chk(lane0_write_strobe_out, PADS[0], "first position");
        chk(lane0_write_strobe_oe, 1'h1, "oe after capture");
        for (int k = 1; k < `CHAIN_LEN + 2; k++) begin
            exp = (k < `CHAIN_LEN) ? PADS[k] : 1'h0;
            if (k + 1 == `POS_RESERVED_A || k + 1 == `POS_RESERVED_B) begin
                exp = 1'h0;
            end
            tester.strobe(1'h1, 1'h0);
            chk(lane0_write_strobe_out, exp, "shifted position");
        end
        tester.strobe(1'h1, 1'h1);
        chk(lane0_write_strobe_oe, 1'h0, "oe disabled");
        pad_in = ~PADS;
        tester.strobe(1'h0, 1'h0);
        chk(lane0_write_strobe_out, ~PADS[0], "recapture first");
        tester.strobe(1'h1, 1'h0);
        chk(lane0_write_strobe_out, ~PADS[1], "recapture second");
    endtask : t_chain
    task automatic t_leave();
        tester.leave();
        tester.cyc(5);
        chk(scan_active, 1'h0, "active after exit");
        chk(term_dq_en, 1'h1, "dq term after exit");
        chk(lane0_write_strobe_out, 1'h1, "strobe out after exit");
        chk(lane0_write_strobe_oe, 1'h1, "strobe oe after exit");
        chk(core_cmd_block, 1'h0, "cmd block after exit");
        chk(core_init_hold, 1'h1, "init hold after exit");
        chk(core_chip_select_n, 1'h0, "chip select after exit");
    endtask : t_leave

    initial begin
        arst_n = 1'h0;
        norm_strobe_out = 1'h0;
        norm_strobe_oe = 1'h0;
        norm_init_hold = 1'h0;
        pad_in = '0;
        repeat (6) @(posedge clk_sys);
        #1;
        arst_n = 1'h1;
        tester.cyc(2);
        t_normal();
        t_enter();
        t_chain();
        t_leave();
        wrap_up();
    end
endmodule : mem_boundary_scan_tb
